// ### src/upconv_regs_pkg.sv
// Constants for the upconverter control register bank.
package upconv_regs_pkg;

  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 48;

  // Register offsets as seen on the serial control port.
  localparam logic [4:0] CLK_CFG_ADDR    = 5'h02;
  localparam logic [4:0] FSC_ADDR        = 5'h03;
  localparam logic [4:0] UPD_RATE_ADDR   = 5'h04;
  localparam logic [4:0] SEG_A_ADDR      = 5'h05;
  localparam logic [4:0] SEG_B_ADDR      = 5'h06;
  localparam logic [4:0] AMP_ADDR        = 5'h09;

  // Writable bit masks; every other position reads as zero.
  localparam logic [31:0] CLK_CFG_MASK   = 32'h3738_c1fe;
  localparam logic [31:0] FSC_MASK       = 32'h0000_00ff;
  localparam logic [31:0] UPD_RATE_MASK  = 32'hffff_ffff;
  localparam logic [47:0] SEG_MASK       = 48'hffff_ffc0_ffc7;
  localparam logic [31:0] AMP_MASK       = 32'hffff_ffff;

  // Reset values.
  localparam logic [31:0] CLK_CFG_RST    = 32'h1738_4000;
  localparam logic [31:0] FSC_RST        = 32'h0000_00ff;
  localparam logic [31:0] UPD_RATE_RST   = 32'h0fff_ffff;
  localparam logic [47:0] SEG_RST        = 48'h0000_0000_0000;
  localparam logic [31:0] AMP_RST        = 32'h0000_0000;

  // Field positions in the clock configuration word.
  localparam int unsigned DRV_LSB        = 28;
  localparam int unsigned BAND_LSB       = 24;
  localparam int unsigned CP_LSB         = 19;
  localparam int unsigned DIV_BYP_BIT    = 15;
  localparam int unsigned DIV_RSTN_BIT   = 14;
  localparam int unsigned PLL_EN_BIT     = 8;
  localparam int unsigned FBDIV_LSB      = 1;

  // Field positions in a playback segment descriptor.
  localparam int unsigned SEG_STEP_LSB   = 32;
  localparam int unsigned SEG_END_LSB    = 22;
  localparam int unsigned SEG_START_LSB  = 6;
  localparam int unsigned SEG_MODE_LSB   = 0;

  // Field positions in the amplitude scale word.
  localparam int unsigned AMP_RATE_LSB   = 16;
  localparam int unsigned AMP_SCALE_LSB  = 2;
  localparam int unsigned AMP_STEP_LSB   = 0;

endpackage

// ### src/upconv_regs.sv
// Control register bank of the quadrature upconverter with segment trigger and keying logic.
`timescale 1ns/1ps
`default_nettype none

module upconv_regs
  import upconv_regs_pkg::*;
(
  input  wire logic              CLK_SYS_I,               // System clock, 40 MHz.
  input  wire logic              RST_N_I,                 // Synchronous reset, active low.
  input  wire logic              REG_WR_I,                // Write strobe from serial port.
  input  wire logic              REG_RD_I,                // Read strobe from serial port.
  input  wire logic [ADDR_W-1:0] REG_ADDR_I,              // Register address.
  input  wire logic [DATA_W-1:0] REG_WDATA_I,             // Write data, low aligned.
  input  wire logic              IO_UPDATE_I,             // Update transfer event pulse.
  input  wire logic              RAM_ENABLE_I,            // First control word bit 31.
  input  wire logic              OSK_ENABLE_I,            // First control word bit 9.
  input  wire logic              AUTO_OSK_I,              // First control word bit 8.
  input  wire logic              MANUAL_OSK_I,            // First control word bit 23.
  input  wire logic              AUTO_UPDATE_EN_I,        // Second control word bit 23.
  input  wire logic              SEGMENT_TRIGGER_PIN_I,   // Segment trigger pin.
  input  wire logic              AMPLITUDE_KEYING_PIN_I,  // Amplitude keying pin.
  output logic [DATA_W-1:0]      REG_RDATA_O,             // Read data, two cycles after read.
  output logic [1:0]             REFOUT_DRIVE_SELECT_O,   // Reference output pin drive.
  output logic [2:0]             OSCILLATOR_BAND_SELECT_O,// Oscillator band.
  output logic [2:0]             CP_CURRENT_O,            // Charge pump current.
  output logic                   REFDIV_BYPASS_O,         // Input divider bypass.
  output logic                   REFDIV_RESET_N_O,        // Input divider reset, active low.
  output logic                   PLL_ENABLE_O,            // Multiplying loop enable.
  output logic [6:0]             PLL_FB_DIV_O,            // Feedback divider modulus.
  output logic [7:0]             FULLSCALE_CURRENT_CODE_O,// Main converter full-scale code.
  output logic [31:0]            AUTO_UPDATE_INTERVAL_O,  // Automatic update interval.
  output logic                   AUTO_UPDATE_ACTIVE_O,    // Interval is in force.
  output logic                   SEG_ACTIVE_O,            // A segment governs playback.
  output logic                   SEG_SELECT_O,            // 0 first segment, 1 second.
  output logic                   SEG_LOAD_O,              // Pulse when a segment is chosen.
  output logic [15:0]            SEG_STEP_O,              // Step interval.
  output logic [9:0]             SEG_END_O,               // Final address.
  output logic [9:0]             SEG_START_O,             // First address.
  output logic [2:0]             SEG_MODE_O,              // Playback mode.
  output logic                   AMP_SCALE_VALID_O,       // Direct scale in force.
  output logic [13:0]            AMP_SCALE_O,             // Direct scale factor.
  output logic                   AMP_RAMP_ACTIVE_O,       // Automatic ramping in force.
  output logic [13:0]            AMP_CEILING_O,           // Ramp ceiling.
  output logic [15:0]            AMP_RAMP_RATE_O,         // Ramp update rate.
  output logic [1:0]             AMP_STEP_O               // Ramp step size select.
);

  // Applies a field mask so unassigned positions never store a one.
  function automatic logic [DATA_W-1:0] masked(input logic [DATA_W-1:0] v,
                                               input logic [DATA_W-1:0] m);
    masked = v & m;
  endfunction

  // Written (staged) copies and the copies the operating logic uses.
  logic [31:0]       clk_cfg_q;
  logic [31:0]       clk_cfg_d;
  logic [31:0]       clk_act_q;
  logic [31:0]       clk_act_d;
  logic [31:0]       fsc_q;
  logic [31:0]       fsc_d;
  logic [31:0]       fsc_act_q;
  logic [31:0]       fsc_act_d;
  logic [31:0]       amp_q;
  logic [31:0]       amp_d;
  logic [31:0]       amp_act_q;
  logic [31:0]       amp_act_d;
  logic [47:0]       seg_b_q;
  logic [47:0]       seg_b_d;
  logic [47:0]       seg_b_act_q;
  logic [47:0]       seg_b_act_d;

  // Words that act at once keep a single copy.
  logic [31:0]       upd_rate_q;
  logic [31:0]       upd_rate_d;
  logic [47:0]       seg_a_q;
  logic [47:0]       seg_a_d;

  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;

  always_comb
  begin
    clk_cfg_d  = clk_cfg_q;
    fsc_d      = fsc_q;
    amp_d      = amp_q;
    upd_rate_d = upd_rate_q;
    seg_a_d    = seg_a_q;
    seg_b_d    = seg_b_q;
    if (REG_WR_I)
    begin
      unique case (REG_ADDR_I)
        CLK_CFG_ADDR:  clk_cfg_d  = 32'(masked(REG_WDATA_I, 48'(CLK_CFG_MASK)));
        FSC_ADDR:      fsc_d      = 32'(masked(REG_WDATA_I, 48'(FSC_MASK)));
        UPD_RATE_ADDR: upd_rate_d = 32'(masked(REG_WDATA_I, 48'(UPD_RATE_MASK)));
        SEG_A_ADDR:    seg_a_d    = masked(REG_WDATA_I, SEG_MASK);
        SEG_B_ADDR:    seg_b_d    = masked(REG_WDATA_I, SEG_MASK);
        AMP_ADDR:      amp_d      = 32'(masked(REG_WDATA_I, 48'(AMP_MASK)));
        default:       ;
      endcase
    end
  end

  // Staged words reach the operating copies only on an update event.
  always_comb
  begin
    clk_act_d = clk_act_q;
    fsc_act_d = fsc_act_q;
    amp_act_d = amp_act_q;
    // The second segment waits for the update event; only the first acts at once.
    seg_b_act_d = seg_b_act_q;
    if (IO_UPDATE_I)
    begin
      clk_act_d = clk_cfg_q;
      fsc_act_d = fsc_q;
      amp_act_d = amp_q;
      seg_b_act_d = seg_b_q;
    end
  end

  // Reads return the written words; unmapped addresses read zero.
  // The answer reaches the port one edge after the edge that takes the read strobe.
  always_comb
  begin
    rdata_d = '0;
    if (REG_RD_I)
    begin
      unique case (REG_ADDR_I)
        CLK_CFG_ADDR:  rdata_d = 48'(clk_cfg_q);
        FSC_ADDR:      rdata_d = 48'(fsc_q);
        UPD_RATE_ADDR: rdata_d = 48'(upd_rate_q);
        SEG_A_ADDR:    rdata_d = seg_a_q;
        SEG_B_ADDR:    rdata_d = seg_b_q;
        AMP_ADDR:      rdata_d = 48'(amp_q);
        default:       rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RST_N_I)
    begin
      clk_cfg_q  <= CLK_CFG_RST;
      clk_act_q  <= CLK_CFG_RST;
      fsc_q      <= FSC_RST;
      fsc_act_q  <= FSC_RST;
      amp_q      <= AMP_RST;
      amp_act_q  <= AMP_RST;
      upd_rate_q <= UPD_RATE_RST;
      seg_a_q    <= SEG_RST;
      seg_b_q    <= SEG_RST;
      seg_b_act_q <= SEG_RST;
      rdata_q    <= '0;
    end
    else
    begin
      clk_cfg_q  <= clk_cfg_d;
      clk_act_q  <= clk_act_d;
      fsc_q      <= fsc_d;
      fsc_act_q  <= fsc_act_d;
      amp_q      <= amp_d;
      amp_act_q  <= amp_act_d;
      upd_rate_q <= upd_rate_d;
      seg_a_q    <= seg_a_d;
      seg_b_q    <= seg_b_d;
      seg_b_act_q <= seg_b_act_d;
      rdata_q    <= rdata_d;
    end
  end

  // Pin synchronisers; the first stage feeds only the second.
  logic trig_meta_q;
  logic trig_sync_q;
  logic trig_prev_q;
  logic key_meta_q;
  logic key_sync_q;

  logic seg_active_q;
  logic seg_active_d;
  logic seg_sel_q;
  logic seg_sel_d;
  logic seg_load_q;
  logic seg_load_d;
  logic trig_rise;
  logic trig_fall;

  // The detector starts low, so a pin held high through reset shows as a rising edge.
  assign trig_rise = trig_sync_q & ~trig_prev_q;
  assign trig_fall = ~trig_sync_q & trig_prev_q;

  // Dropping the enable clears the active flag but keeps the chosen segment.
  always_comb
  begin
    seg_active_d = seg_active_q & RAM_ENABLE_I;
    seg_sel_d    = seg_sel_q;
    seg_load_d   = 1'b0;
    if (RAM_ENABLE_I && trig_rise)
    begin
      seg_active_d = 1'b1;
      seg_sel_d    = 1'b0;
      seg_load_d   = 1'b1;
    end
    else if (RAM_ENABLE_I && trig_fall)
    begin
      seg_active_d = 1'b1;
      seg_sel_d    = 1'b1;
      seg_load_d   = 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RST_N_I)
    begin
      trig_meta_q  <= 1'b0;
      trig_sync_q  <= 1'b0;
      trig_prev_q  <= 1'b0;
      key_meta_q   <= 1'b0;
      key_sync_q   <= 1'b0;
      seg_active_q <= 1'b0;
      seg_sel_q    <= 1'b0;
      seg_load_q   <= 1'b0;
    end
    else
    begin
      trig_meta_q  <= SEGMENT_TRIGGER_PIN_I;
      trig_sync_q  <= trig_meta_q;
      trig_prev_q  <= trig_sync_q;
      key_meta_q   <= AMPLITUDE_KEYING_PIN_I;
      key_sync_q   <= key_meta_q;
      seg_active_q <= seg_active_d;
      seg_sel_q    <= seg_sel_d;
      seg_load_q   <= seg_load_d;
    end
  end

  // Output stage: every top-level output is a flip-flop.
  logic [47:0] seg_cur;
  logic [13:0] amp_field;
  logic        direct_ok;
  logic [1:0]  drv_d;
  logic [2:0]  band_d;
  logic [2:0]  cp_d;
  logic [2:0]  mode_d;
  logic        byp_d;
  logic        rstn_d;
  logic        pll_d;
  logic        upd_act_d;
  logic        scale_vld_d;
  logic        ramp_act_d;
  logic [6:0]  fbdiv_d;
  logic [7:0]  fsc_out_d;
  logic [15:0] step_d;
  logic [15:0] rate_d;
  logic [9:0]  end_d;
  logic [9:0]  start_d;
  logic [13:0] scale_d;
  logic [13:0] ceil_d;
  logic [1:0]  ampstep_d;

  // Level inputs show one edge late; the keying pin waits two more in its synchroniser.
  always_comb
  begin
    seg_cur     = seg_sel_q ? seg_b_act_q : seg_a_q;
    amp_field   = amp_act_q[AMP_SCALE_LSB +: 14];
    drv_d       = clk_act_q[DRV_LSB +: 2];
    band_d      = clk_act_q[BAND_LSB +: 3];
    cp_d        = clk_act_q[CP_LSB +: 3];
    byp_d       = clk_act_q[DIV_BYP_BIT];
    rstn_d      = clk_act_q[DIV_RSTN_BIT];
    pll_d       = clk_act_q[PLL_EN_BIT];
    fbdiv_d     = clk_act_q[FBDIV_LSB +: 7];
    fsc_out_d   = fsc_act_q[7:0];
    upd_act_d   = AUTO_UPDATE_EN_I;
    step_d      = seg_cur[SEG_STEP_LSB +: 16];
    end_d       = seg_cur[SEG_END_LSB +: 10];
    start_d     = seg_cur[SEG_START_LSB +: 10];
    mode_d      = seg_cur[SEG_MODE_LSB +: 3];
    // Direct scaling holds unless the keying mode is on and the pin is low.
    direct_ok   = ~MANUAL_OSK_I | key_sync_q;
    scale_vld_d = OSK_ENABLE_I & ~AUTO_OSK_I & direct_ok;
    scale_d     = scale_vld_d ? amp_field : 14'h0000;
    ramp_act_d  = OSK_ENABLE_I & AUTO_OSK_I;
    ceil_d      = ramp_act_d ? amp_field : 14'h0000;
    rate_d      = ramp_act_d ? amp_act_q[AMP_RATE_LSB +: 16] : 16'h0000;
    ampstep_d   = ramp_act_d ? amp_act_q[AMP_STEP_LSB +: 2] : 2'h0;
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RST_N_I)
    begin
      REFOUT_DRIVE_SELECT_O    <= CLK_CFG_RST[DRV_LSB +: 2];
      OSCILLATOR_BAND_SELECT_O <= CLK_CFG_RST[BAND_LSB +: 3];
      CP_CURRENT_O             <= CLK_CFG_RST[CP_LSB +: 3];
      REFDIV_BYPASS_O          <= CLK_CFG_RST[DIV_BYP_BIT];
      REFDIV_RESET_N_O         <= CLK_CFG_RST[DIV_RSTN_BIT];
      PLL_ENABLE_O             <= CLK_CFG_RST[PLL_EN_BIT];
      PLL_FB_DIV_O             <= CLK_CFG_RST[FBDIV_LSB +: 7];
      FULLSCALE_CURRENT_CODE_O <= FSC_RST[7:0];
      AUTO_UPDATE_INTERVAL_O   <= UPD_RATE_RST;
      AUTO_UPDATE_ACTIVE_O     <= 1'b0;
      SEG_ACTIVE_O             <= 1'b0;
      SEG_SELECT_O             <= 1'b0;
      SEG_LOAD_O               <= 1'b0;
      SEG_STEP_O               <= 16'h0000;
      SEG_END_O                <= 10'h000;
      SEG_START_O              <= 10'h000;
      SEG_MODE_O               <= 3'h0;
      AMP_SCALE_VALID_O        <= 1'b0;
      AMP_SCALE_O              <= 14'h0000;
      AMP_RAMP_ACTIVE_O        <= 1'b0;
      AMP_CEILING_O            <= 14'h0000;
      AMP_RAMP_RATE_O          <= 16'h0000;
      AMP_STEP_O               <= 2'h0;
      REG_RDATA_O              <= '0;
    end
    else
    begin
      REFOUT_DRIVE_SELECT_O    <= drv_d;
      OSCILLATOR_BAND_SELECT_O <= band_d;
      CP_CURRENT_O             <= cp_d;
      REFDIV_BYPASS_O          <= byp_d;
      REFDIV_RESET_N_O         <= rstn_d;
      PLL_ENABLE_O             <= pll_d;
      PLL_FB_DIV_O             <= fbdiv_d;
      FULLSCALE_CURRENT_CODE_O <= fsc_out_d;
      AUTO_UPDATE_INTERVAL_O   <= upd_rate_q;
      AUTO_UPDATE_ACTIVE_O     <= upd_act_d;
      SEG_ACTIVE_O             <= seg_active_q;
      SEG_SELECT_O             <= seg_sel_q;
      SEG_LOAD_O               <= seg_load_q;
      SEG_STEP_O               <= step_d;
      SEG_END_O                <= end_d;
      SEG_START_O              <= start_d;
      SEG_MODE_O               <= mode_d;
      AMP_SCALE_VALID_O        <= scale_vld_d;
      AMP_SCALE_O              <= scale_d;
      AMP_RAMP_ACTIVE_O        <= ramp_act_d;
      AMP_CEILING_O            <= ceil_d;
      AMP_RAMP_RATE_O          <= rate_d;
      AMP_STEP_O               <= ampstep_d;
      REG_RDATA_O              <= rdata_q;
    end
  end

endmodule

`default_nettype wire

// ### sim/host_model.sv
// Host model that drives the register port of the control bank.
`timescale 1ns/1ps
`default_nettype none
module host_model
  import upconv_regs_pkg::*;
(
  input  wire logic              clk_i,   // System clock.
  input  wire logic [DATA_W-1:0] rdata_i, // Read data.
  output logic                   wr_o,    // Write strobe.
  output logic                   rd_o,    // Read strobe.
  output logic [ADDR_W-1:0]      addr_o,  // Address.
  output logic [DATA_W-1:0]      wdata_o  // Write data.
);
  initial
  begin
    wr_o    = 1'b0;
    rd_o    = 1'b0;
    addr_o  = 5'h1f;
    wdata_o = 48'h0;
  end
  // Released lines show the inverse so a stale value is never mistaken for a fresh one.
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge clk_i);
    addr_o  = a;
    wdata_o = d;
    wr_o    = 1'b1;
    @(negedge clk_i);
    wr_o    = 1'b0;
    addr_o  = ~a;
    wdata_o = ~d;
  endtask
  task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(negedge clk_i);
    addr_o = a;
    rd_o   = 1'b1;
    @(negedge clk_i);
    rd_o   = 1'b0;
    addr_o = ~a;
    // The answer stands for one cycle, between the first and second edges after the strobe.
    @(posedge clk_i);
    @(negedge clk_i);
    d = rdata_i;
  endtask
endmodule
`default_nettype wire

// ### sim/upconv_regs_chk.sv
// Concurrent checks on the ports of the control register bank.
`timescale 1ns/1ps
`default_nettype none
module upconv_regs_chk
  import upconv_regs_pkg::*;
(
  input wire logic              CLK_SYS_I,
  input wire logic              RST_N_I,
  input wire logic              REG_RD_I,
  input wire logic [ADDR_W-1:0] REG_ADDR_I,
  input wire logic              IO_UPDATE_I,
  input wire logic              RAM_ENABLE_I,
  input wire logic              AUTO_UPDATE_EN_I,
  input wire logic [DATA_W-1:0] REG_RDATA_O,
  input wire logic [2:0]        OSCILLATOR_BAND_SELECT_O,
  input wire logic [6:0]        PLL_FB_DIV_O,
  input wire logic [7:0]        FULLSCALE_CURRENT_CODE_O,
  input wire logic              AUTO_UPDATE_ACTIVE_O,
  input wire logic              SEG_ACTIVE_O,
  input wire logic              SEG_LOAD_O,
  input wire logic              AMP_SCALE_VALID_O,
  input wire logic [13:0]       AMP_SCALE_O,
  input wire logic              AMP_RAMP_ACTIVE_O,
  input wire logic [13:0]       AMP_CEILING_O,
  input wire logic [15:0]       AMP_RAMP_RATE_O,
  input wire logic [1:0]        AMP_STEP_O
);
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!RST_N_I);
  property p_rd_unmapped;
    $past(REG_RD_I, 2) && !($past(REG_ADDR_I, 2) inside {5'h02, 5'h03, 5'h04, 5'h05, 5'h06,
      5'h09}) |-> REG_RDATA_O == 48'h0;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
  property p_clk_open;
    $past(REG_RD_I, 2) && $past(REG_ADDR_I, 2) == 5'h02 |-> (REG_RDATA_O & ~48'h3738_c1fe) == 48'h0;
  endproperty
  a_clk_open: assert property (p_clk_open) else $error("clock word open bit set");
  property p_seg_open;
    $past(REG_RD_I, 2) && $past(REG_ADDR_I, 2) inside {5'h05, 5'h06}
      |-> REG_RDATA_O[21:16] == 6'h0 && REG_RDATA_O[5:3] == 3'h0;
  endproperty
  a_seg_open: assert property (p_seg_open) else $error("segment open bit set");
  property p_staged;
    $changed({OSCILLATOR_BAND_SELECT_O, PLL_FB_DIV_O, FULLSCALE_CURRENT_CODE_O})
      |-> $past(IO_UPDATE_I, 1) || $past(IO_UPDATE_I, 2) || $past(IO_UPDATE_I, 3);
  endproperty
  a_staged: assert property (p_staged) else $error("staged output moved without update");
  property p_upd_active;
    $past(RST_N_I) |-> AUTO_UPDATE_ACTIVE_O == $past(AUTO_UPDATE_EN_I);
  endproperty
  a_upd_active: assert property (p_upd_active) else $error("interval enable mismatch");
  property p_load_pulse;
    SEG_LOAD_O |=> !SEG_LOAD_O;
  endproperty
  a_load_pulse: assert property (p_load_pulse) else $error("segment load too long");
  property p_seg_ram;
    SEG_ACTIVE_O |-> $past(RAM_ENABLE_I, 2);
  endproperty
  a_seg_ram: assert property (p_seg_ram) else $error("segment active without enable");
  property p_amp_idle;
    !AMP_SCALE_VALID_O |-> AMP_SCALE_O == 14'h0;
  endproperty
  a_amp_idle: assert property (p_amp_idle) else $error("scale shown while not valid");
  property p_ramp_idle;
    !AMP_RAMP_ACTIVE_O |-> {AMP_CEILING_O, AMP_RAMP_RATE_O, AMP_STEP_O} == 32'h0;
  endproperty
  a_ramp_idle: assert property (p_ramp_idle) else $error("ramp shown while idle");
  property p_amp_excl;
    !(AMP_SCALE_VALID_O && AMP_RAMP_ACTIVE_O);
  endproperty
  a_amp_excl: assert property (p_amp_excl) else $error("direct scale and ramp together");
endmodule
bind upconv_regs upconv_regs_chk i_upconv_regs_chk (.*);
`default_nettype wire

// ### sim/test_upconv_regs.sv
// Self-checking testbench of the control register bank.
`timescale 1ns/1ps
`default_nettype none
module test_upconv_regs
  import upconv_regs_pkg::*;
;
  logic CLK_SYS_I, RST_N_I, REG_WR_I, REG_RD_I, IO_UPDATE_I, RAM_ENABLE_I, OSK_ENABLE_I;
  logic AUTO_OSK_I, MANUAL_OSK_I, AUTO_UPDATE_EN_I, SEGMENT_TRIGGER_PIN_I, AMPLITUDE_KEYING_PIN_I;
  logic REFDIV_BYPASS_O, REFDIV_RESET_N_O, PLL_ENABLE_O, AUTO_UPDATE_ACTIVE_O, SEG_ACTIVE_O;
  logic SEG_SELECT_O, SEG_LOAD_O, AMP_SCALE_VALID_O, AMP_RAMP_ACTIVE_O;
  logic [4:0]  REG_ADDR_I;
  logic [47:0] REG_WDATA_I, REG_RDATA_O, clk_out, seg_out, amp_out;
  logic [1:0]  REFOUT_DRIVE_SELECT_O, AMP_STEP_O;
  logic [2:0]  OSCILLATOR_BAND_SELECT_O, CP_CURRENT_O, SEG_MODE_O;
  logic [6:0]  PLL_FB_DIV_O;
  logic [7:0]  FULLSCALE_CURRENT_CODE_O;
  logic [31:0] AUTO_UPDATE_INTERVAL_O;
  logic [15:0] SEG_STEP_O, AMP_RAMP_RATE_O;
  logic [9:0]  SEG_END_O, SEG_START_O;
  logic [13:0] AMP_SCALE_O, AMP_CEILING_O;
  int          err_total, samples_checked;
  assign clk_out = {30'h0, REFOUT_DRIVE_SELECT_O, OSCILLATOR_BAND_SELECT_O, CP_CURRENT_O,
                    REFDIV_BYPASS_O, REFDIV_RESET_N_O, PLL_ENABLE_O, PLL_FB_DIV_O};
  assign seg_out = {7'h0, SEG_ACTIVE_O, SEG_SELECT_O, SEG_STEP_O, SEG_END_O, SEG_START_O, SEG_MODE_O};
  assign amp_out = {AMP_SCALE_VALID_O, AMP_SCALE_O, AMP_RAMP_ACTIVE_O, AMP_CEILING_O,
                    AMP_RAMP_RATE_O, AMP_STEP_O};
  upconv_regs i_upconv_regs (.*);
  host_model i_host_model (.clk_i(CLK_SYS_I), .rdata_i(REG_RDATA_O), .wr_o(REG_WR_I),
                           .rd_o(REG_RD_I), .addr_o(REG_ADDR_I), .wdata_o(REG_WDATA_I));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [47:0] e, input logic [47:0] g);
    samples_checked++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [47:0] e, input string n);
    logic [47:0] d;
    i_host_model.rd_reg(a, d);
    chk(n, e, d);
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge CLK_SYS_I);
  endtask
  task automatic upd();
    @(negedge CLK_SYS_I);
    IO_UPDATE_I = 1'b1;
    wt(1);
    IO_UPDATE_I = 1'b0;
    wt(4);
  endtask
  task automatic t_reset();
    rdchk(CLK_CFG_ADDR, 48'h1738_4000, "clk_rd");
    chk("clk_out", 48'h1fd00, clk_out);
    rdchk(FSC_ADDR, 48'hff, "fsc_rd");
    chk("fsc_out", 48'hff, 48'(FULLSCALE_CURRENT_CODE_O));
    rdchk(UPD_RATE_ADDR, 48'h0fff_ffff, "rate_rd");
    chk("rate_out", 48'h0fff_ffff, 48'(AUTO_UPDATE_INTERVAL_O));
    chk("seg_out", 48'h0, seg_out);
    chk("amp_out", 48'h0, amp_out);
  endtask
  task automatic t_clk_cfg();
    i_host_model.wr_reg(CLK_CFG_ADDR, 48'hffff_ffff_ffff);
    wt(4);
    chk("clk_held", 48'h1fd00, clk_out);
    rdchk(CLK_CFG_ADDR, 48'h3738_c1fe, "clk_rd");
    upd();
    chk("clk_ones", 48'h3ffff, clk_out);
    i_host_model.wr_reg(CLK_CFG_ADDR, 48'h0);
    upd();
    chk("clk_zero", 48'h0, clk_out);
  endtask
  task automatic t_fsc();
    i_host_model.wr_reg(FSC_ADDR, 48'hffff_ffff_ff12);
    rdchk(FSC_ADDR, 48'h12, "fsc_rd");
    chk("fsc_held", 48'hff, 48'(FULLSCALE_CURRENT_CODE_O));
    upd();
    chk("fsc_out", 48'h12, 48'(FULLSCALE_CURRENT_CODE_O));
  endtask
  task automatic t_unmapped();
    logic [4:0] a[3] = '{5'h00, 5'h07, 5'h0a};
    foreach (a[i])
    begin
      i_host_model.wr_reg(a[i], 48'hffff_ffff_ffff);
      rdchk(a[i], 48'h0, "unmapped_rd");
    end
    rdchk(FSC_ADDR, 48'h12, "fsc_kept");
  endtask
  task automatic t_interval();
    i_host_model.wr_reg(UPD_RATE_ADDR, 48'hffff_1234_5678);
    wt(3);
    chk("rate_out", 48'h1234_5678, 48'(AUTO_UPDATE_INTERVAL_O));
    chk("rate_idle", 48'h0, 48'(AUTO_UPDATE_ACTIVE_O));
    AUTO_UPDATE_EN_I = 1'b1;
    wt(2);
    chk("rate_act", 48'h1, 48'(AUTO_UPDATE_ACTIVE_O));
    rdchk(UPD_RATE_ADDR, 48'h1234_5678, "rate_rd");
  endtask
  task automatic t_segments();
    i_host_model.wr_reg(SEG_A_ADDR, 48'hffff_ffff_ffff);
    i_host_model.wr_reg(SEG_B_ADDR, 48'h1234_5678_9abc);
    rdchk(SEG_A_ADDR, 48'hffff_ffc0_ffc7, "seg_a_rd");
    rdchk(SEG_B_ADDR, 48'h1234_5640_9a84, "seg_b_rd");
    upd();
    RAM_ENABLE_I = 1'b1;
    SEGMENT_TRIGGER_PIN_I = 1'b1;
    wt(4);
    chk("seg_load", 48'h1, 48'(SEG_LOAD_O));
    wt(1);
    chk("seg_load_end", 48'h0, 48'(SEG_LOAD_O));
    wt(1);
    chk("seg_a", {7'h0, 2'b10, 16'hffff, 10'h3ff, 10'h3ff, 3'h7}, seg_out);
    SEGMENT_TRIGGER_PIN_I = 1'b0;
    wt(6);
    chk("seg_b", {7'h0, 2'b11, 16'h1234, 10'h159, 10'h26a, 3'h4}, seg_out);
    i_host_model.wr_reg(SEG_B_ADDR, 48'h0);
    wt(3);
    chk("seg_b_held", {7'h0, 2'b11, 16'h1234, 10'h159, 10'h26a, 3'h4}, seg_out);
    upd();
    chk("seg_b_new", {7'h0, 2'b11, 39'h0}, seg_out);
    SEGMENT_TRIGGER_PIN_I = 1'b1;
    wt(6);
    for (int m = 0; m < 8; m++)
    begin
      i_host_model.wr_reg(SEG_A_ADDR, 48'(m));
      wt(3);
      chk("seg_mode", {7'h0, 2'b10, 36'h0, 3'(m)}, seg_out);
    end
    RAM_ENABLE_I = 1'b0;
    wt(3);
    chk("seg_off", 48'h0, 48'(SEG_ACTIVE_O));
    SEGMENT_TRIGGER_PIN_I = 1'b0;
    wt(6);
    chk("seg_noedge", 48'h0, 48'({SEG_ACTIVE_O, SEG_SELECT_O}));
  endtask
  task automatic t_amp();
    i_host_model.wr_reg(AMP_ADDR, 48'hffff_abcd_5679);
    rdchk(AMP_ADDR, 48'habcd_5679, "amp_rd");
    upd();
    chk("amp_off", 48'h0, amp_out);
    OSK_ENABLE_I = 1'b1;
    wt(3);
    chk("amp_direct", {1'b1, 14'h159e, 33'h0}, amp_out);
    MANUAL_OSK_I = 1'b1;
    wt(6);
    chk("amp_key_lo", 48'h0, amp_out);
    AMPLITUDE_KEYING_PIN_I = 1'b1;
    wt(6);
    chk("amp_key_hi", {1'b1, 14'h159e, 33'h0}, amp_out);
    AUTO_OSK_I = 1'b1;
    wt(3);
    chk("amp_ramp", {15'h0, 1'b1, 14'h159e, 16'habcd, 2'h1}, amp_out);
    OSK_ENABLE_I = 1'b0;
    wt(3);
    chk("amp_gone", 48'h0, amp_out);
  endtask
  initial
  begin
    CLK_SYS_I = 1'b0;
    forever #12.5 CLK_SYS_I = ~CLK_SYS_I;
  end
  initial
  begin
    #(25 * 20000);
    err_total++;
    end_sim();
  end
  initial
  begin
    {RST_N_I, IO_UPDATE_I, RAM_ENABLE_I, OSK_ENABLE_I, AUTO_OSK_I, MANUAL_OSK_I} = 6'h0;
    {AUTO_UPDATE_EN_I, SEGMENT_TRIGGER_PIN_I, AMPLITUDE_KEYING_PIN_I} = 3'h0;
    err_total = 0;
    samples_checked = 0;
    repeat (2) @(posedge CLK_SYS_I);
    @(negedge CLK_SYS_I);
    RST_N_I = 1'b1;
    t_reset();
    t_clk_cfg();
    t_fsc();
    t_unmapped();
    t_interval();
    t_segments();
    t_amp();
    end_sim();
  end
endmodule
`default_nettype wire
